// ### src/reset_init_config_integrity_defs.vh
// Constants for the reset, start-up and configuration-integrity block.
// Assumes a 40 MHz system clock; included by its bare name.
`ifndef RESET_INIT_CONFIG_INTEGRITY_DEFS_VH
`define RESET_INIT_CONFIG_INTEGRITY_DEFS_VH

// Clock and timing
`define CLK_PERIOD_NS 25
`define INIT_TIME_MS 20
`define INIT_CYCLES ((`INIT_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RST_LOW_MIN_NS 1000
`define RST_LOW_CYCLES ((`RST_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Configuration store layout: 16 words, last holds the sum of the others
`define CFG_WORDS 16
`define CFG_SUM_IDX 4'hF
`define CFG_GPIO_OE 4'h0
`define CFG_GPIO_OUT 4'h1
`define CFG_FAST_PWM_PINS_OE 4'h2
`define CFG_FAST_PWM_PINS_OUT 4'h3
`define CFG_CTRL 4'h4
`define CFG_TP_OE 4'h5
`define CFG_TP_OUT 4'h6
`define CFG_DEFAULT 32'h00000000
`define CTRL_SEQ_BIT 0

// Allowed-bit masks for range checking
`define MASK_GPIO 32'h0003FFFF
`define MASK_FAST_PWM_PINS 32'h000000FF
`define MASK_CTRL 32'h00000001
`define MASK_TP 32'h0000000F
`define MASK_OPEN 32'hFFFFFFFF

// Address select bins and fallback address
`define BIN_MIN 4'h4
`define BIN_MAX 4'hB
`define BIN_SCALE 7'h0C
`define ADDR_FALLBACK 7'h7E

// Test-port instructions
`define IR_PROG 4'h8
`define IR_BYPASS 4'hF
`endif

// ### src/reset_init_config_integrity.v
// Reset sequencing, timed initialization, configuration load/store with ECC,
// and the programming-only test access port of the rail sequencer.
// Assumes all inputs synchronous to i_sys_clk; the flash answers a read in the
// next cycle and accepts one write per cycle.
//
// Overview of operation
// - Hold reset until supply above threshold
// - Long low on reset pin holds reset
// - Leave reset within 1 ms of release
// - Every reset exit runs 20 ms initialization
// - Init: fast PWM low, other pins undriven
// - After init apply stored pin configuration
// - Factory config: fast PWM low, other pins undriven, no sequencing
// - Bus writes change RAM copy only
// - Store-all copies RAM into data flash
// - Test port off by default, pins are GPIO
// - Blank flash enables test port
// - Address 126 enables test port
// - Test port: TAP for programming only
// - Four test pins reusable as GPIO
// - Firmware sum mismatch: firmware not run
// - Config sum mismatch: defaults; alert and flag unless flash blank
// - Error log checked by its own sum
// - Watchdog expiry performs a normal reset
// - Range check every received parameter
// - Six check bits per 32-bit flash word
// - Correct single-bit errors on flash read
// - Address is 12 x upper bin + lower
`include "reset_init_config_integrity_defs.vh"

module reset_init_config_integrity #(
  parameter [19:0] INIT_CYCLES = `INIT_CYCLES
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_supply_ok,
  input wire i_ext_reset_n,
  input wire i_wdt_expire,
  input wire [3:0] i_addr_bin_hi,
  input wire [3:0] i_addr_bin_lo,
  input wire [15:0] i_fw_sum,
  input wire [15:0] i_fw_sum_ref,
  input wire [15:0] i_log_sum,
  input wire [15:0] i_log_sum_ref,
  input wire i_cfg_wr,
  input wire [3:0] i_cfg_addr,
  input wire [31:0] i_cfg_data,
  input wire i_store_all,
  input wire [37:0] i_flash_rdata,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  output reg o_in_reset,
  output reg o_init_active,
  output reg o_normal_run,
  output reg o_fw_run,
  output reg o_seq_enable,
  output reg o_cfg_err,
  output reg o_bus_alert,
  output reg o_log_err,
  output reg o_jtag_en,
  output reg [6:0] o_bus_addr,
  output reg o_cfg_reject,
  output reg o_store_busy,
  output reg o_ecc_corrected,
  output reg o_flash_rd,
  output reg o_flash_wr,
  output reg [3:0] o_flash_addr,
  output reg [37:0] o_flash_wdata,
  output reg [17:0] o_gpio_out,
  output reg [17:0] o_gpio_oe,
  output reg [7:0] o_fast_pwm_pins_out,
  output reg [7:0] o_fast_pwm_pins_oe,
  output reg [3:0] o_tp_out,
  output reg [3:0] o_tp_oe,
  output reg o_tdo,
  output reg o_tdo_oe
);

  localparam [1:0] ST_RESET = 2'd0;
  localparam [1:0] ST_INIT = 2'd1;
  localparam [1:0] ST_RUN = 2'd2;
  localparam [3:0] TLR = 4'd0, RTI = 4'd1, SDS = 4'd2, CDR = 4'd3;
  localparam [3:0] SDR = 4'd4, E1D = 4'd5, PDR = 4'd6, E2D = 4'd7;
  localparam [3:0] UDR = 4'd8, SIS = 4'd9, CIR = 4'd10, SIR = 4'd11;
  localparam [3:0] E1I = 4'd12, PIR = 4'd13, E2I = 4'd14, UIR = 4'd15;
  localparam [11:0] LOW_MAX = `RST_LOW_CYCLES;

  // Hamming SEC code: parity at positions 1,2,4,8,16,32 of 38
  function [37:0] ecc_encode;
    input [31:0] d;
    integer i, j, k;
    reg [38:1] c;
    reg p;
    begin
      c = 38'h0;
      j = 0;
      for (i = 1; i <= 38; i = i + 1) begin
        if ((i & (i - 1)) != 0) begin
          c[i] = d[j];
          j = j + 1;
        end
      end
      for (k = 0; k < 6; k = k + 1) begin
        p = 1'b0;
        for (i = 1; i <= 38; i = i + 1)
          if (i[k])
            p = p ^ c[i];
        c[1 << k] = p;
      end
      ecc_encode = c;
    end
  endfunction

  function [5:0] ecc_syndrome;
    input [37:0] w;
    integer i, k;
    reg [38:1] c;
    begin
      c = w;
      ecc_syndrome = 6'h0;
      for (k = 0; k < 6; k = k + 1)
        for (i = 1; i <= 38; i = i + 1)
          if (i[k])
            ecc_syndrome[k] = ecc_syndrome[k] ^ c[i];
    end
  endfunction

  function [31:0] ecc_correct;
    input [37:0] w;
    input [5:0] s;
    integer i, j;
    reg [38:1] c;
    begin
      c = w;
      ecc_correct = 32'h0;
      j = 0;
      for (i = 1; i <= 38; i = i + 1)
        if (s == i)
          c[i] = ~c[i];
      for (i = 1; i <= 38; i = i + 1) begin
        if ((i & (i - 1)) != 0) begin
          ecc_correct[j] = c[i];
          j = j + 1;
        end
      end
    end
  endfunction

  // Allowed bits per word; the sum word is never writable directly
  function [31:0] cfg_mask;
    input [3:0] a;
    begin
      case (a)
        `CFG_GPIO_OE, `CFG_GPIO_OUT: cfg_mask = `MASK_GPIO;
        `CFG_FAST_PWM_PINS_OE, `CFG_FAST_PWM_PINS_OUT: cfg_mask = `MASK_FAST_PWM_PINS;
        `CFG_CTRL: cfg_mask = `MASK_CTRL;
        `CFG_TP_OE, `CFG_TP_OUT: cfg_mask = `MASK_TP;
        default: cfg_mask = `MASK_OPEN;
      endcase
    end
  endfunction

  reg [31:0] ram [0:`CFG_WORDS-1];
  reg [1:0] state;
  reg [19:0] init_cnt;
  reg [11:0] low_cnt;
  reg [4:0] ld_idx;
  reg rd_pend;
  reg [3:0] rd_idx;
  reg [31:0] ld_sum;
  reg ld_sum_ok;
  reg ld_blank;
  reg [4:0] st_idx;
  reg [31:0] st_sum;
  reg fw_ok;
  reg [3:0] tap;
  reg [3:0] next_tap;
  reg [3:0] ir;
  reg [3:0] ir_sh;
  reg [35:0] dr_sh;
  reg tck_q;
  reg tp_wr;
  reg [35:0] tp_word;

  wire ext_low_long = !i_ext_reset_n && (low_cnt == LOW_MAX);
  wire hold_reset = !i_supply_ok || ext_low_long || i_wdt_expire;
  wire [5:0] rd_syn = ecc_syndrome(i_flash_rdata);
  wire [31:0] rd_data = ecc_correct(i_flash_rdata, rd_syn);
  wire bins_ok = (i_addr_bin_hi >= `BIN_MIN) && (i_addr_bin_hi <= `BIN_MAX) &&
    (i_addr_bin_lo >= `BIN_MIN) && (i_addr_bin_lo <= `BIN_MAX);
  wire [6:0] addr_calc = bins_ok ?
    ({3'h0, i_addr_bin_hi} * `BIN_SCALE) + {3'h0, i_addr_bin_lo} : `ADDR_FALLBACK;
  wire init_done = (state == ST_INIT) && (init_cnt == INIT_CYCLES - 20'd1);
  wire tck_rise = i_tck && !tck_q;
  wire run_wr_ok = (state == ST_RUN) && !o_store_busy;
  wire bus_wr = i_cfg_wr && run_wr_ok;
  // The sum word only ever comes from a store; a direct write would hide corruption
  wire bus_ok = ((i_cfg_data & ~cfg_mask(i_cfg_addr)) == 32'h0) && (i_cfg_addr != `CFG_SUM_IDX);
  wire tp_ok = ((tp_word[31:0] & ~cfg_mask(tp_word[35:32])) == 32'h0) && (tp_word[35:32] != `CFG_SUM_IDX);

  // Reset pin low time; a short glitch never reaches the count limit
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt <= 12'h000;
    end else if (i_ext_reset_n) begin
      low_cnt <= 12'h000;
    end else if (low_cnt != LOW_MAX) begin
      low_cnt <= low_cnt + 12'h001;
    end
  end

  // Main sequence: reset, timed init with flash load, normal run
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_RESET;
      init_cnt <= 20'h00000;
    end else if (hold_reset) begin
      state <= ST_RESET;
      init_cnt <= 20'h00000;
    end else begin
      case (state)
        ST_RESET: state <= ST_INIT;
        ST_INIT: begin
          init_cnt <= init_cnt + 20'h00001;
          if (init_done)
            state <= ST_RUN;
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_RESET;
      endcase
    end
  end

  // Flash load, checks at end of init, RAM writes and store-all
  always @(posedge i_sys_clk or negedge i_reset_n) begin : cfg_proc
    integer n;
    if (!i_reset_n) begin
      ld_idx <= 5'h00;
      rd_pend <= 1'b0;
      rd_idx <= 4'h0;
      ld_sum <= 32'h0;
      ld_sum_ok <= 1'b0;
      ld_blank <= 1'b1;
      st_idx <= 5'h00;
      st_sum <= 32'h0;
      fw_ok <= 1'b0;
      o_cfg_err <= 1'b0;
      o_bus_alert <= 1'b0;
      o_log_err <= 1'b0;
      o_jtag_en <= 1'b0;
      o_bus_addr <= `ADDR_FALLBACK;
      o_cfg_reject <= 1'b0;
      o_store_busy <= 1'b0;
      o_ecc_corrected <= 1'b0;
      o_flash_rd <= 1'b0;
      o_flash_wr <= 1'b0;
      o_flash_addr <= 4'h0;
      o_flash_wdata <= 38'h0;
      for (n = 0; n < `CFG_WORDS; n = n + 1)
        ram[n] <= `CFG_DEFAULT;
    end else begin
      o_flash_rd <= 1'b0;
      o_flash_wr <= 1'b0;
      o_cfg_reject <= 1'b0;
      o_ecc_corrected <= 1'b0;
      rd_pend <= o_flash_rd;
      rd_idx <= o_flash_addr;
      if (state == ST_RESET) begin
        ld_idx <= 5'h00;
        ld_sum <= 32'h0;
        ld_sum_ok <= 1'b0;
        ld_blank <= 1'b1;
        st_idx <= 5'h00;
        o_store_busy <= 1'b0;
        rd_pend <= 1'b0;
      end
      if (state == ST_INIT && ld_idx != 5'h10) begin
        o_flash_rd <= 1'b1;
        o_flash_addr <= ld_idx[3:0];
        ld_idx <= ld_idx + 5'h01;
      end
      if (rd_pend && state == ST_INIT) begin
        ram[rd_idx] <= rd_data;
        o_ecc_corrected <= (rd_syn != 6'h0);
        if (i_flash_rdata != {38{1'b1}})
          ld_blank <= 1'b0;
        if (rd_idx == `CFG_SUM_IDX)
          ld_sum_ok <= (ld_sum == rd_data);
        else
          ld_sum <= ld_sum + rd_data;
      end
      if (init_done) begin
        fw_ok <= (i_fw_sum == i_fw_sum_ref);
        o_log_err <= (i_log_sum != i_log_sum_ref);
        o_bus_addr <= addr_calc;
        o_jtag_en <= ld_blank || (addr_calc == `ADDR_FALLBACK);
        if (!ld_sum_ok) begin
          o_cfg_err <= !ld_blank;
          o_bus_alert <= !ld_blank;
          for (n = 0; n < `CFG_WORDS; n = n + 1)
            ram[n] <= `CFG_DEFAULT;
        end
      end
      // Only the RAM copy changes here; flash waits for store-all
      if (bus_wr) begin
        if (bus_ok)
          ram[i_cfg_addr] <= i_cfg_data;
        else
          o_cfg_reject <= 1'b1;
      end else if (tp_wr && run_wr_ok) begin
        if (tp_ok)
          ram[tp_word[35:32]] <= tp_word[31:0];
        else
          o_cfg_reject <= 1'b1;
      end
      if (i_store_all && run_wr_ok) begin
        o_store_busy <= 1'b1;
        st_idx <= 5'h00;
        st_sum <= 32'h0;
      end
      if (o_store_busy && state == ST_RUN) begin
        o_flash_wr <= 1'b1;
        o_flash_addr <= st_idx[3:0];
        if (st_idx[3:0] == `CFG_SUM_IDX) begin
          o_flash_wdata <= ecc_encode(st_sum);
          o_store_busy <= 1'b0;
        end else begin
          o_flash_wdata <= ecc_encode(ram[st_idx[3:0]]);
          st_sum <= st_sum + ram[st_idx[3:0]];
        end
        st_idx <= st_idx + 5'h01;
      end
    end
  end

  // Pin drive: safe levels in reset and init, stored config afterwards
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_in_reset <= 1'b1;
      o_init_active <= 1'b0;
      o_normal_run <= 1'b0;
      o_fw_run <= 1'b0;
      o_seq_enable <= 1'b0;
      o_gpio_out <= 18'h0;
      o_gpio_oe <= 18'h0;
      o_fast_pwm_pins_out <= 8'h00;
      o_fast_pwm_pins_oe <= 8'hFF;
      o_tp_out <= 4'h0;
      o_tp_oe <= 4'h0;
    end else begin
      o_in_reset <= (state == ST_RESET);
      o_init_active <= (state == ST_INIT);
      o_normal_run <= (state == ST_RUN);
      o_fw_run <= (state == ST_RUN) && fw_ok;
      if (state == ST_RUN) begin
        o_seq_enable <= fw_ok && ram[`CFG_CTRL][`CTRL_SEQ_BIT];
        o_gpio_out <= ram[`CFG_GPIO_OUT][17:0];
        o_gpio_oe <= ram[`CFG_GPIO_OE][17:0];
        o_fast_pwm_pins_out <= ram[`CFG_FAST_PWM_PINS_OUT][7:0];
        o_fast_pwm_pins_oe <= ram[`CFG_FAST_PWM_PINS_OE][7:0] | ~ram[`CFG_FAST_PWM_PINS_OUT][7:0]; // low when not configured
        o_tp_out <= o_jtag_en ? 4'h0 : ram[`CFG_TP_OUT][3:0];
        o_tp_oe <= o_jtag_en ? 4'h0 : ram[`CFG_TP_OE][3:0];
      end else begin
        o_seq_enable <= 1'b0;
        o_gpio_out <= 18'h0;
        o_gpio_oe <= 18'h0;
        o_fast_pwm_pins_out <= 8'h00;
        o_fast_pwm_pins_oe <= 8'hFF;
        o_tp_out <= 4'h0;
        o_tp_oe <= 4'h0;
      end
    end
  end

  // Test access port state walk
  always @* begin
    case (tap)
      TLR: next_tap = i_tms ? TLR : RTI;
      RTI: next_tap = i_tms ? SDS : RTI;
      SDS: next_tap = i_tms ? SIS : CDR;
      CDR: next_tap = i_tms ? E1D : SDR;
      SDR: next_tap = i_tms ? E1D : SDR;
      E1D: next_tap = i_tms ? UDR : PDR;
      PDR: next_tap = i_tms ? E2D : PDR;
      E2D: next_tap = i_tms ? UDR : SDR;
      UDR: next_tap = i_tms ? SDS : RTI;
      SIS: next_tap = i_tms ? TLR : CIR;
      CIR: next_tap = i_tms ? E1I : SIR;
      SIR: next_tap = i_tms ? E1I : SIR;
      E1I: next_tap = i_tms ? UIR : PIR;
      PIR: next_tap = i_tms ? E2I : PIR;
      E2I: next_tap = i_tms ? UIR : SIR;
      UIR: next_tap = i_tms ? SDS : RTI;
      default: next_tap = TLR;
    endcase
  end

  // Programming-only TAP; any instruction but the program word acts as bypass
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tck_q <= 1'b0;
      tap <= TLR;
      ir <= `IR_BYPASS;
      ir_sh <= 4'h0;
      dr_sh <= 36'h0;
      tp_wr <= 1'b0;
      tp_word <= 36'h0;
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      tck_q <= i_tck;
      tp_wr <= 1'b0;
      if (!o_jtag_en || state != ST_RUN) begin
        tap <= TLR;
        ir <= `IR_BYPASS;
        o_tdo_oe <= 1'b0;
      end else if (tck_rise) begin
        tap <= next_tap;
        case (tap)
          TLR: ir <= `IR_BYPASS;
          CIR: ir_sh <= 4'h1;
          SIR: ir_sh <= {i_tdi, ir_sh[3:1]};
          UIR: ir <= ir_sh;
          CDR: dr_sh <= 36'h0;
          SDR: dr_sh <= (ir == `IR_PROG) ? {i_tdi, dr_sh[35:1]} : {35'h0, i_tdi};
          UDR: begin
            if (ir == `IR_PROG) begin
              tp_wr <= 1'b1;
              tp_word <= dr_sh;
            end
          end
          default: tp_wr <= 1'b0;
        endcase
        o_tdo <= (next_tap == SIR) ? ir_sh[0] : dr_sh[0];
        o_tdo_oe <= (next_tap == SIR) || (next_tap == SDR);
      end
    end
  end

endmodule

// ### bench/reset_init_config_integrity_checker.sv
// Assertions on the reset, start-up and store ports of the block.
// Assumes one clock domain and the active-low asynchronous reset.
module reset_init_config_integrity_checker #(
  parameter [19:0] INIT_CYCLES = 20'h00040
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_supply_ok,
  input wire i_ext_reset_n,
  input wire i_wdt_expire,
  input wire i_cfg_wr,
  input wire [3:0] i_cfg_addr,
  input wire o_in_reset,
  input wire o_init_active,
  input wire o_normal_run,
  input wire o_fw_run,
  input wire o_cfg_err,
  input wire o_bus_alert,
  input wire o_jtag_en,
  input wire [6:0] o_bus_addr,
  input wire o_cfg_reject,
  input wire o_store_busy,
  input wire o_ecc_corrected,
  input wire o_flash_wr,
  input wire [3:0] o_flash_addr,
  input wire [17:0] o_gpio_oe,
  input wire [7:0] o_fast_pwm_pins_out,
  input wire [7:0] o_fast_pwm_pins_oe,
  input wire [3:0] o_tp_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic [5:0] ext_lo;
  logic [19:0] init_cnt;
  // Run lengths of a low reset pin and of the start-up phase
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_lo <= 6'h00;
      init_cnt <= 20'h00000;
    end else begin
      ext_lo <= i_ext_reset_n ? 6'h00 : (ext_lo == 6'h28 ? ext_lo : ext_lo + 6'h01);
      init_cnt <= o_init_active ? init_cnt + 20'h00001 : 20'h00000;
    end
  end
  property p_supply_hold; !i_supply_ok |-> ##[1:2] o_in_reset; endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("supply low without reset");
  property p_pin_hold; ext_lo == 6'h28 |-> ##[0:3] o_in_reset; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("held reset pin ignored");
  property p_wdt; i_wdt_expire |-> ##[1:2] o_in_reset; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog expiry without reset");
  property p_exit; $fell(o_in_reset) |-> o_init_active; endproperty
  a_exit: assert property (p_exit) else $error("reset exit skipped start-up");
  property p_init_len; $fell(o_init_active) && o_normal_run |-> init_cnt == INIT_CYCLES; endproperty
  a_init_len: assert property (p_init_len) else $error("start-up length wrong");
  // Pins stay safe across reset and start-up alike
  property p_safe_pins;
    o_in_reset || o_init_active |-> o_fast_pwm_pins_oe == 8'hFF && o_fast_pwm_pins_out == 8'h00 && o_gpio_oe == 18'h00000
      && o_tp_oe == 4'h0;
  endproperty
  a_safe_pins: assert property (p_safe_pins) else $error("pins driven in reset or start-up");
  property p_id_held; o_normal_run && $past(o_normal_run) |-> $stable(o_jtag_en) && $stable(o_bus_addr); endproperty
  a_id_held: assert property (p_id_held) else $error("address or port enable moved");
  property p_alert; o_cfg_err |-> o_bus_alert; endproperty
  a_alert: assert property (p_alert) else $error("config error without alert");
  property p_store;
    $rose(o_store_busy) |-> ##1 (o_flash_wr && o_flash_addr == 4'h0) ##1 o_flash_wr [*7] ##1 o_flash_wr [*8];
  endproperty
  a_store: assert property (p_store) else $error("store burst wrong");
  property p_ram_only; o_flash_wr |-> o_store_busy || $past(o_store_busy); endproperty
  a_ram_only: assert property (p_ram_only) else $error("flash written outside store");
  property p_sum_reject;
    o_normal_run && !o_store_busy && i_cfg_wr && i_cfg_addr == 4'hF |-> ##[1:2] o_cfg_reject;
  endproperty
  a_sum_reject: assert property (p_sum_reject) else $error("sum word write accepted");
  property p_fw; o_fw_run |-> o_normal_run; endproperty
  a_fw: assert property (p_fw) else $error("firmware runs outside normal run");
  property p_tp; o_jtag_en |-> o_tp_oe == 4'h0; endproperty
  a_tp: assert property (p_tp) else $error("test pins driven while port enabled");
  c_store: cover property ($rose(o_store_busy));
  c_err: cover property ($rose(o_cfg_err));
  c_ecc: cover property (o_ecc_corrected);
endmodule

bind reset_init_config_integrity reset_init_config_integrity_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
  .i_sys_clk, .i_reset_n, .i_supply_ok, .i_ext_reset_n, .i_wdt_expire, .i_cfg_wr, .i_cfg_addr,
  .o_in_reset, .o_init_active, .o_normal_run, .o_fw_run, .o_cfg_err, .o_bus_alert, .o_jtag_en,
  .o_bus_addr, .o_cfg_reject, .o_store_busy, .o_ecc_corrected, .o_flash_wr, .o_flash_addr,
  .o_gpio_oe, .o_fast_pwm_pins_out, .o_fast_pwm_pins_oe, .o_tp_oe
);

// ### bench/flash_model.sv
// Data flash behind the block: 16 codewords, blank (all ones) at start.
// Assumes one read answered the next cycle; faults flip bits on load only.
module flash_model (
  input wire i_sys_clk,
  input wire i_rd,
  input wire i_wr,
  input wire [3:0] i_addr,
  input wire [37:0] i_wdata,
  input wire [1:0] i_fault,
  output logic [37:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [37:0] mem [0:15];
  logic [37:0] mask;
  initial begin
    for (int k = 0; k < 16; k++) mem[k] = '1;
    o_rdata = 38'h0;
  end
  // Fault 1: one flipped bit in word 0; fault 2: two flipped bits in the sum word
  assign mask = (i_fault == 2'h1 && i_addr == 4'h0) ? 38'h0000000400 :
                (i_fault == 2'h2 && i_addr == 4'hF) ? 38'h0000001400 : 38'h0;
  // Idle data toggles so a stale word never looks valid
  always @(posedge i_sys_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    o_rdata <= i_rd ? mem[i_addr] ^ mask : ~o_rdata;
  end
endmodule

// ### bench/reset_init_config_integrity_bench.sv
// Self-checking bench: boots, parameter writes, store, reload and faults.
// Assumes the block with a shortened start-up and the flash model beside it.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module reset_init_config_integrity_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [19:0] INIT = 20'h00040;
  logic i_sys_clk, i_reset_n, i_supply_ok, i_ext_reset_n, i_wdt_expire, i_cfg_wr, i_store_all, seen_ecc;
  logic i_tck, i_tms, i_tdi;
  logic [3:0] i_addr_bin_hi, i_addr_bin_lo, i_cfg_addr;
  logic [15:0] i_fw_sum, i_fw_sum_ref, i_log_sum, i_log_sum_ref;
  logic [31:0] i_cfg_data;
  logic [1:0] fault;
  wire [37:0] i_flash_rdata, o_flash_wdata;
  wire o_in_reset, o_init_active, o_normal_run, o_fw_run, o_seq_enable, o_cfg_err, o_bus_alert, o_log_err;
  wire o_jtag_en, o_cfg_reject, o_store_busy, o_ecc_corrected, o_flash_rd, o_flash_wr, o_tdo, o_tdo_oe;
  wire [6:0] o_bus_addr;
  wire [3:0] o_flash_addr, o_tp_out, o_tp_oe;
  wire [17:0] o_gpio_out, o_gpio_oe;
  wire [7:0] o_fast_pwm_pins_out, o_fast_pwm_pins_oe;
  int mismatches, num_checks, nwr;

  // Test port driven by the bench at half the system clock rate or slower
  reset_init_config_integrity #(.INIT_CYCLES(INIT)) i_reset_init_config_integrity (
    .i_sys_clk, .i_reset_n, .i_supply_ok, .i_ext_reset_n, .i_wdt_expire, .i_addr_bin_hi, .i_addr_bin_lo,
    .i_fw_sum, .i_fw_sum_ref, .i_log_sum, .i_log_sum_ref, .i_cfg_wr, .i_cfg_addr, .i_cfg_data, .i_store_all,
    .i_flash_rdata, .i_tck, .i_tms, .i_tdi, .o_in_reset, .o_init_active, .o_normal_run,
    .o_fw_run, .o_seq_enable, .o_cfg_err, .o_bus_alert, .o_log_err, .o_jtag_en, .o_bus_addr, .o_cfg_reject,
    .o_store_busy, .o_ecc_corrected, .o_flash_rd, .o_flash_wr, .o_flash_addr, .o_flash_wdata, .o_gpio_out,
    .o_gpio_oe, .o_fast_pwm_pins_out, .o_fast_pwm_pins_oe, .o_tp_out, .o_tp_oe, .o_tdo, .o_tdo_oe
  );
  flash_model i_flash_model (
    .i_sys_clk, .i_rd(o_flash_rd), .i_wr(o_flash_wr), .i_addr(o_flash_addr), .i_wdata(o_flash_wdata),
    .i_fault(fault), .o_rdata(i_flash_rdata)
  );

  // 40 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Flash writes and corrections seen on the ports
  always @(posedge i_sys_clk) begin
    if (o_flash_wr === 1'b1) nwr++;
    if (o_ecc_corrected === 1'b1) seen_ecc = 1'b1;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Leaves the current run, then waits through start-up into normal run
  task automatic wait_run();
    int k, n;
    k = 0;
    n = 0;
    while (o_normal_run === 1'b1 && k < 50) begin @(posedge i_sys_clk); k++; end
    while (o_normal_run !== 1'b1 && k < 400) begin
      @(posedge i_sys_clk);
      k++;
      if (o_init_active === 1'b1) n++;
      if (n == 8) begin
        `CHK(o_fast_pwm_pins_oe, 8'hFF)
        `CHK(o_fast_pwm_pins_out, 8'h00)
        `CHK({o_gpio_oe, o_tp_oe}, 22'h000000)
      end
    end
    `CHK(o_normal_run, 1'b1)
    `CHK(n, INIT)
  endtask

  // One parameter write; a refusal shows up one or two cycles after it is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic bad);
    logic r;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= a;
    i_cfg_data <= d;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b0;
    @(posedge i_sys_clk);
    r = o_cfg_reject;
    @(posedge i_sys_clk);
    r = r | o_cfg_reject;
    `CHK(r, bad)
  endtask

  // One test-clock period: levels set, then a rising edge one cycle later
  task automatic tap_step(input logic ms, input logic di);
    @(posedge i_sys_clk);
    i_tck <= 1'b0;
    i_tms <= ms;
    i_tdi <= di;
    @(posedge i_sys_clk);
    i_tck <= 1'b1;
  endtask

  task automatic t_blank();
    wait_run();
    `CHK(o_jtag_en, 1'b1)
    `CHK(o_bus_addr, 7'h43)
    `CHK(o_cfg_err, 1'b0)
    `CHK(o_seq_enable, 1'b0)
    `CHK({o_fast_pwm_pins_oe, o_fast_pwm_pins_out}, 16'hFF00)
    `CHK(o_gpio_oe, 18'h00000)
  endtask

  task automatic t_write();
    int k;
    nwr = 0;
    wr(4'h0, 32'h0003FFFF, 1'b0);
    wr(4'h1, 32'h00015555, 1'b0);
    wr(4'h2, 32'h00000100, 1'b1);
    wr(4'h3, 32'h000000F0, 1'b0);
    wr(4'h4, 32'h00000002, 1'b1);
    wr(4'h4, 32'h00000001, 1'b0);
    wr(4'h5, 32'h0000000F, 1'b0);
    wr(4'h6, 32'h00000005, 1'b0);
    wr(4'hF, 32'h00000000, 1'b1);
    `CHK(nwr, 0)
    `CHK(o_gpio_oe, 18'h3FFFF)
    `CHK(o_seq_enable, 1'b1)
    `CHK(o_tp_oe, 4'h0)
    @(posedge i_sys_clk);
    i_store_all <= 1'b1;
    @(posedge i_sys_clk);
    i_store_all <= 1'b0;
    wr(4'h0, 32'h00000000, 1'b0);
    k = 0;
    while (o_store_busy === 1'b1 && k < 40) begin @(posedge i_sys_clk); k++; end
    repeat (3) @(posedge i_sys_clk);
    `CHK(nwr, 16)
    `CHK(o_gpio_oe, 18'h3FFFF)
  endtask

  task automatic t_reload();
    i_addr_bin_hi <= 4'h4;
    i_addr_bin_lo <= 4'h4;
    i_ext_reset_n <= 1'b0;
    repeat (45) @(posedge i_sys_clk);
    `CHK(o_in_reset, 1'b1)
    i_ext_reset_n <= 1'b1;
    wait_run();
    `CHK(o_jtag_en, 1'b0)
    `CHK(o_bus_addr, 7'h34)
    `CHK({o_tp_oe, o_tp_out}, 8'hF5)
    `CHK({o_gpio_oe, o_gpio_out}, 36'hFFFFD5555)
    `CHK({o_fast_pwm_pins_oe, o_fast_pwm_pins_out}, 16'h0FF0)
    `CHK({o_seq_enable, o_cfg_err}, 2'h2)
  endtask

  task automatic t_ecc();
    fault <= 2'h1;
    seen_ecc = 1'b0;
    i_supply_ok <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    `CHK(o_in_reset, 1'b1)
    i_supply_ok <= 1'b1;
    wait_run();
    `CHK(seen_ecc, 1'b1)
    `CHK(o_gpio_oe, 18'h3FFFF)
    `CHK(o_cfg_err, 1'b0)
  endtask

  task automatic t_bad();
    fault <= 2'h2;
    i_addr_bin_hi <= 4'h0;
    i_addr_bin_lo <= 4'h5;
    i_fw_sum <= 16'h1235;
    i_log_sum <= 16'h0ABD;
    @(posedge i_sys_clk);
    i_wdt_expire <= 1'b1;
    @(posedge i_sys_clk);
    i_wdt_expire <= 1'b0;
    wait_run();
    `CHK({o_cfg_err, o_bus_alert}, 2'h3)
    `CHK(o_gpio_oe, 18'h00000)
    `CHK({o_fw_run, o_seq_enable}, 2'h0)
    `CHK(o_log_err, 1'b1)
    `CHK({o_jtag_en, o_bus_addr}, 8'hFE)
  endtask

  // Program word 0 through the test port: IR 8, then a 36-bit word, LSB first
  task automatic t_tap();
    logic [35:0] w;
    w = 36'h000000003;
    tap_step(1'b0, 1'b0);
    tap_step(1'b1, 1'b0);
    tap_step(1'b1, 1'b0);
    tap_step(1'b0, 1'b0);
    tap_step(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) tap_step(i == 3, i == 3);
    tap_step(1'b1, 1'b0);
    tap_step(1'b1, 1'b0);
    tap_step(1'b0, 1'b0);
    tap_step(1'b0, 1'b0);
    for (int i = 0; i < 36; i++) begin
      tap_step(i == 35, w[i]);
      if (i == 8) `CHK(o_tdo_oe, 1'b1)
    end
    tap_step(1'b1, 1'b0);
    tap_step(1'b0, 1'b0);
    repeat (4) @(posedge i_sys_clk);
    `CHK(o_gpio_oe, 18'h00003)
  endtask

  // Inputs valid at time zero, reset held for 8 cycles
  initial begin
    i_reset_n = 1'b0;
    i_supply_ok = 1'b1;
    i_ext_reset_n = 1'b1;
    i_wdt_expire = 1'b0;
    i_cfg_wr = 1'b0;
    i_store_all = 1'b0;
    i_addr_bin_hi = 4'h5;
    i_addr_bin_lo = 4'h7;
    i_cfg_addr = 4'h0;
    i_cfg_data = 32'h00000000;
    i_fw_sum = 16'h1234;
    i_fw_sum_ref = 16'h1234;
    i_log_sum = 16'h0ABC;
    i_log_sum_ref = 16'h0ABC;
    fault = 2'h0;
    i_tck = 1'b0;
    i_tms = 1'b0;
    i_tdi = 1'b0;
    mismatches = 0;
    num_checks = 0;
    nwr = 0;
    seen_ecc = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_blank();
    t_write();
    t_reload();
    t_ecc();
    t_bad();
    t_tap();
    complete_run();
  end

  // Whole run needs about 500 cycles; a hang is cut off well after that
  initial begin
    repeat (6000) @(posedge i_sys_clk);
    mismatches++;
    complete_run();
  end
endmodule
